//--- hdl/htde_core.sv
// Top of the humidity/temperature duty encoder.
// Assumes an external measurement engine answering a one-cycle request
// with raw codes already scaled to the duty range; routing pin is async.
// Functional notes
// - One humidity and one temperature measurement each second, each converted to duty.
// - Routing high: output A humidity, B temperature; low: swapped.
// - Duty is high time over total period, from 0 to 1; this design tops out at 4095/4096.
// - Duty follows the measurement linearly, no nonlinear mapping.
// - Humidity percent equals -6 plus 125 times duty.
// - Temperature Celsius equals -46.85 plus 175.72 times duty.
// - Humidity slightly below 0 or above 100 percent passes unclamped.
`timescale 1ns/1ps
module htde_core #(
  parameter int DUTY_W = htde_pkg::DUTY_W,
  parameter int MEAS_CYCLES = htde_pkg::MEAS_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic route_sel,
  input wire logic [DUTY_W-1:0] rh_code,
  input wire logic [DUTY_W-1:0] temp_code,
  input wire logic meas_done,
  output logic meas_req,
  output logic duty_out_a,
  output logic duty_out_b
);
  // Counters below are sized for these limits
  if (DUTY_W < 4 || DUTY_W > 16)
  begin : g_bad_width
    $error("htde_core: duty width must be 4 to 16 bits");
  end

  if (MEAS_CYCLES < 2)
  begin : g_bad_interval
    $error("htde_core: measurement interval below two cycles");
  end

  typedef struct packed
  {
    // Routing pin path
    logic sel_m;
    logic sel_s;
    logic sel_d;

    // Interval and handshake
    logic [31:0] tick;
    htde_pkg::htde_state_type st;
    logic [htde_pkg::WAIT_W-1:0] wait_cnt;
    logic req;

    // Held results, kept as a pair
    logic have_res;
    logic [DUTY_W-1:0] rh;
    logic [DUTY_W-1:0] tc;

    // Routed codes and reload strobe for the channels
    logic [DUTY_W-1:0] duty_a;
    logic [DUTY_W-1:0] duty_b;
    logic load;
  } htde_core_type;

  htde_core_type r;
  htde_core_type next_r;

  logic tick_end;
  logic sel_moved;
  logic answer_open;
  logic take;

  logic pwm_a;
  logic pwm_b;

  assign tick_end = (r.tick == 32'(MEAS_CYCLES - 1));

  // settled routing level differs from the one last applied
  assign sel_moved = (r.sel_s != r.sel_d);

  // A fast engine may answer while the request still stands
  assign answer_open = (r.st == htde_pkg::HTDE_REQ) || (r.st == htde_pkg::HTDE_WAIT);
  assign take = answer_open && meas_done;

  always_comb
  begin
    next_r = r;
    next_r.load = 1'b0;
    next_r.req = 1'b0;

    next_r.sel_m = route_sel;
    next_r.sel_s = r.sel_m;
    next_r.sel_d = r.sel_s;

    if (tick_end)
    begin
      next_r.tick = htde_pkg::TICK_RESET;
    end
    else
    begin
      next_r.tick = r.tick + 32'h0000_0001;
    end

    // a new level reloads the held pair now, not a second later
    if (sel_moved && r.have_res)
    begin
      next_r.load = 1'b1;
    end

    if (take)
    begin
      next_r.rh = rh_code;
      next_r.tc = temp_code;
      next_r.have_res = 1'b1;
      next_r.load = 1'b1;
    end

    case (r.st)
      htde_pkg::HTDE_IDLE:
      begin
        next_r.wait_cnt = '0;
        if (tick_end)
        begin
          next_r.req = 1'b1;
          next_r.st = htde_pkg::HTDE_REQ;
        end
      end

      htde_pkg::HTDE_REQ:
      begin
        next_r.wait_cnt = '0;
        if (take)
        begin
          next_r.st = htde_pkg::HTDE_IDLE;
        end
        else
        begin
          next_r.st = htde_pkg::HTDE_WAIT;
        end
      end

      htde_pkg::HTDE_WAIT:
      begin
        next_r.wait_cnt = r.wait_cnt + 1'b1;
        if (take)
        begin
          next_r.st = htde_pkg::HTDE_IDLE;
        end
        // A silent engine would otherwise stop every later request
        else if (r.wait_cnt == htde_pkg::WAIT_LIMIT)
        begin
          next_r.st = htde_pkg::HTDE_IDLE;
        end
      end

      default:
      begin
        next_r.wait_cnt = '0;
        next_r.st = htde_pkg::HTDE_IDLE;
      end
    endcase

    // routing applied to the pair handed to the channels
    if (next_r.sel_s)
    begin
      next_r.duty_a = next_r.rh;
      next_r.duty_b = next_r.tc;
    end
    else
    begin
      next_r.duty_a = next_r.tc;
      next_r.duty_b = next_r.rh;
    end
  end

  // Async clear; the state field needs its one-hot idle code
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.st <= htde_pkg::HTDE_IDLE;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Both channels share reset, so their periods stay aligned
  // channel A, fixed period with boundary reload
  htde_pwm_channel #(.DUTY_W(DUTY_W)) u_ch_a (
    .clk(clk),
    .rst_n(rst_n),
    .duty(r.duty_a),
    .load(r.load),
    .pwm(pwm_a)
  );

  // channel B, same phase as A
  htde_pwm_channel #(.DUTY_W(DUTY_W)) u_ch_b (
    .clk(clk),
    .rst_n(rst_n),
    .duty(r.duty_b),
    .load(r.load),
    .pwm(pwm_b)
  );

  // Outputs come straight from flip-flops
  assign meas_req = r.req;
  assign duty_out_a = pwm_a;
  assign duty_out_b = pwm_b;

endmodule : htde_core

//--- hdl/htde_pkg.sv
// Package for the humidity/temperature duty encoder.
// Assumes a single 50 MHz clock domain; no software-visible registers.
package htde_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int MEAS_PERIOD_MS = 1000;
  localparam int MEAS_CYCLES = (CLK_HZ / 1000) * MEAS_PERIOD_MS;
  localparam int DUTY_W = 12;
  localparam int PERIOD_CYCLES = 4096;
  localparam logic [DUTY_W-1:0] DUTY_RESET = 12'h000;
  localparam logic [31:0] TICK_RESET = 32'h0000_0000;
  localparam int WAIT_W = 8;
  localparam logic [WAIT_W-1:0] WAIT_LIMIT = 8'hFF;
  typedef enum logic [2:0]
  {
    HTDE_IDLE = 3'b001,
    HTDE_REQ = 3'b010,
    HTDE_WAIT = 3'b100
  } htde_state_type;
endpackage : htde_pkg

//--- hdl/htde_pwm_channel.sv
// One duty-cycle output channel with period-boundary reload.
// Assumes duty and load come from logic on the same clock.
`timescale 1ns/1ps
module htde_pwm_channel #(
  parameter int DUTY_W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [DUTY_W-1:0] duty,
  input wire logic load,
  output logic pwm
);
  typedef struct packed
  {
    logic [DUTY_W-1:0] cnt;
    logic [DUTY_W-1:0] pend;
    logic pend_vld;
    logic [DUTY_W-1:0] act;
    logic pwm;
  } htde_ch_type;
  htde_ch_type r;
  htde_ch_type next_r;
  always_comb
  begin
    next_r = r;
    next_r.cnt = r.cnt + 1'b1;
    if (load)
    begin
      next_r.pend = duty;
      next_r.pend_vld = 1'b1;
    end
    if (r.cnt == '1)
    begin
      if (r.pend_vld || load)
      begin
        next_r.act = load ? duty : r.pend;
        next_r.pend_vld = 1'b0;
      end
    end
    if (next_r.cnt == '0)
      next_r.pwm = (r.cnt == '1) ? (next_r.act != '0) : 1'b0;
    else
      next_r.pwm = next_r.cnt < ((r.cnt == '1) ? next_r.act : r.act);
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else
      r <= next_r;
  end
  assign pwm = r.pwm;
endmodule : htde_pwm_channel

//--- tb/htde_engine_model.sv
// Measurement engine model: answers each request two cycles later.
// Assumes codes come from the bench; shown inverted outside the answer.
`timescale 1ns/1ps
module htde_engine_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic meas_req,
  input wire logic [11:0] rh_val,
  input wire logic [11:0] t_val,
  output logic meas_done,
  output logic [11:0] rh_code,
  output logic [11:0] temp_code
);
  logic d1;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {meas_done, d1} <= 2'h0;
    else
      {meas_done, d1} <= {d1, meas_req};
  // Inverted codes expose any sampling off the answer cycle
  assign rh_code = meas_done ? rh_val : ~rh_val;
  assign temp_code = meas_done ? t_val : ~t_val;
endmodule : htde_engine_model

//--- tb/htde_core_checker.sv
// Checker on the duty encoder top ports.
// Assumes a short measurement interval in simulation.
`timescale 1ns/1ps
module htde_core_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic meas_req,
  input wire logic meas_done,
  input wire logic duty_out_a,
  input wire logic duty_out_b
);
  logic seen;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      seen <= 1'b0;
    else if (meas_done)
      seen <= 1'b1;
  // Period phase: both channels start counting at reset release
  logic [11:0] ph;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ph <= 12'h000;
    else
      ph <= ph + 12'h001;
  a_req_pulse: assert property (meas_req |=> !meas_req [*8])
    else $error("request not a lone pulse");
  a_req_again: assert property (meas_req |-> ##[9:200] meas_req)
    else $error("request interval lost");
  a_no_ghost: assert property (!seen |-> !duty_out_a && !duty_out_b)
    else $error("output high before any result");
  a_a_rise_edge: assert property ($rose(duty_out_a) |-> ph == 12'h000)
    else $error("output A rose inside a period");
  a_b_rise_edge: assert property ($rose(duty_out_b) |-> ph == 12'h000)
    else $error("output B rose inside a period");
  a_last_low: assert property (ph == 12'hFFF |-> !duty_out_a && !duty_out_b)
    else $error("output high in last slot of period");
endmodule : htde_core_checker
bind htde_core htde_core_checker htde_core_checker_inst (.clk, .rst_n, .meas_req,
  .meas_done, .duty_out_a, .duty_out_b);

//--- tb/htde_core_test.sv
// Bench for the duty encoder: routing and duty by counting high cycles.
// Assumes the two-cycle engine model and a 64-cycle interval.
`timescale 1ns/1ps
module htde_core_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic route_sel = 1'b1;
  logic [11:0] rh_val = 12'h000;
  logic [11:0] t_val = 12'h000;
  logic [11:0] rh_code, temp_code;
  logic meas_done, meas_req, duty_out_a, duty_out_b;
  int n_mismatch = 0;
  int total_checks = 0;
  always #10 clk = ~clk;
  htde_core #(.MEAS_CYCLES(64)) htde_core_inst (.clk, .rst_n, .route_sel, .rh_code,
    .temp_code, .meas_done, .meas_req, .duty_out_a, .duty_out_b);
  htde_engine_model htde_engine_model_inst (.clk, .rst_n, .meas_req, .rh_val, .t_val,
    .meas_done, .rh_code, .temp_code);
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // Any 4096-cycle window spans one full period, so its high count is the code
  task automatic run_case(input logic sel, input logic [11:0] rh, input logic [11:0] t);
    logic [12:0] ha;
    logic [12:0] hb;
    ha = 13'h0000;
    hb = 13'h0000;
    @(posedge clk);
    // routing held at a firm level
    route_sel <= sel;
    rh_val <= rh;
    t_val <= t;
    repeat (8400) @(posedge clk);
    repeat (4096)
    begin
      @(negedge clk);
      ha = ha + 13'(duty_out_a);
      hb = hb + 13'(duty_out_b);
    end
    total_checks += 1;
    if (ha !== {1'b0, sel ? rh : t} || hb !== {1'b0, sel ? t : rh})
    begin
      n_mismatch++;
      $display("Error: high counts exp %0h/%0h seen %0h/%0h", sel ? rh : t, sel ? t : rh, ha, hb);
    end
    $display("case done sel=%0d", sel);
  endtask : run_case
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    run_case(1'b1, 12'h400, 12'hC00);
    run_case(1'b0, 12'h400, 12'hC00);
    run_case(1'b1, 12'h000, 12'hFFF);
    run_case(1'b0, 12'h031, 12'hFFE);
    give_verdict();
  end
endmodule : htde_core_test
